// *** common/gpm_regs.svh ***
// Register offsets, field positions, reset values and counts for the GPIO port
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
`define GPM_PORT_BASE        32'h48000000
`define GPM_PORT_STRIDE      32'h00000400
`define GPM_PORT_COUNT       6
`define GPM_DEBUG_PORT       1
`define GPM_OFS_MODE         12'h000
`define GPM_OFS_DRIVE        12'h004
`define GPM_OFS_SLEW         12'h008
`define GPM_OFS_PULL         12'h00C
`define GPM_OFS_SAMPLE       12'h010
`define GPM_OFS_OUTVAL       12'h014
`define GPM_OFS_FREEZE       12'h01C
`define GPM_OFS_AFSEL0       12'h020
`define GPM_OFS_AFSEL1       12'h024
`define GPM_OFS_FLIP         12'h02C
`define GPM_MODE_RST_DEBUG   32'h000A8280
`define GPM_MODE_RST_OTHER   32'h00000000
`define GPM_CFG_RST          32'h00000000
`define GPM_FREEZE_KEY_BIT   16
`define GPM_PULL_UP          2'h1
`define GPM_PULL_DOWN        2'h2
`endif

// *** common/gpm_pkg.sv ***
// Types shared by the GPIO port files
package gpm_pkg;
    typedef enum logic [1:0] {
        GPM_MODE_INPUT  = 2'h0,
        GPM_MODE_OUTPUT = 2'h1,
        GPM_MODE_ALT    = 2'h2,
        GPM_MODE_ANALOG = 2'h3
    } gpm_mode_t;

    // Per-pin pad controls
    typedef struct packed {
        logic out_val;
        logic out_en;
        logic pull_up;
        logic pull_down;
        logic schmitt_en;
    } gpm_pad_ctl_t;

    // Register bus request
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } gpm_bus_req_t;
endpackage

// *** logic/gpm_pad_ctl.sv ***
// Per-pin pad control decode from mode, drive type and pull setting
`include "gpm_regs.svh"
module gpm_pad_ctl (
    input  wire logic              [1:0] mode_i,
    input  wire logic                    open_drain_i,
    input  wire logic              [1:0] pull_i,
    input  wire logic                    gpio_val_i,
    input  wire logic                    alt_val_i,
    input  wire logic                    alt_oe_i,
    output gpm_pkg::gpm_pad_ctl_t        ctl_o
);
    logic drive_val;
    logic drive_on;

    // Output source and driver enable per mode
    always_comb begin
        drive_val = 1'b0;
        drive_on  = 1'b0;
        case (gpm_pkg::gpm_mode_t'(mode_i))
            gpm_pkg::GPM_MODE_OUTPUT: begin
                drive_val = gpio_val_i;
                drive_on  = 1'b1;
            end
            gpm_pkg::GPM_MODE_ALT: begin
                drive_val = alt_val_i;   // [RQ6]
                drive_on  = alt_oe_i;    // [RQ5]
            end
            default: begin
                drive_val = 1'b0;        // [RQ2]
                drive_on  = 1'b0;
            end
        endcase
    end

    // Open drain releases the pad on a high level
    always_comb begin
        ctl_o.out_val    = drive_val;
        ctl_o.out_en     = drive_on && !(open_drain_i && drive_val); // [RQ5]
        ctl_o.schmitt_en = (mode_i != 2'h3); // [RQ3] [RQ7]
        ctl_o.pull_up    = (mode_i != 2'h3) && (pull_i == `GPM_PULL_UP);   // [RQ1]
        ctl_o.pull_down  = (mode_i != 2'h3) && (pull_i == `GPM_PULL_DOWN); // [RQ1]
    end
endmodule

// *** logic/gpm_freeze.sv ***
// Configuration freeze key sequence: write 1, write 0, write 1, then read
`include "gpm_regs.svh"
module gpm_freeze (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] wdata_i,
    output logic      [15:0] frozen_o,
    output logic             key_done_o,
    output logic      [15:0] staged_o
);
    typedef enum logic [1:0] {
        GPM_FRZ_IDLE = 2'h0,
        GPM_FRZ_ONE  = 2'h1,
        GPM_FRZ_ZERO = 2'h2,
        GPM_FRZ_TWO  = 2'h3
    } gpm_frz_t;

    gpm_frz_t    state_q;
    logic [15:0] staged_q;
    logic        key;
    logic        same;

    assign key        = wdata_i[`GPM_FREEZE_KEY_BIT];
    assign same       = (wdata_i[15:0] == staged_q);
    assign staged_o   = staged_q;

    // Key sequence tracker; any deviating write restarts it, a read before the last write is ignored
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q  <= GPM_FRZ_IDLE;
            staged_q <= 16'h0000;
        end else if (key_done_o) begin
            state_q <= GPM_FRZ_IDLE;
        end else if (wr_i) begin
            case (state_q)
                GPM_FRZ_IDLE: begin
                    state_q  <= key ? GPM_FRZ_ONE : GPM_FRZ_IDLE;
                    staged_q <= wdata_i[15:0];
                end
                GPM_FRZ_ONE:  state_q <= (!key && same) ? GPM_FRZ_ZERO : GPM_FRZ_IDLE; // [RQ22]
                GPM_FRZ_ZERO: state_q <= (key && same) ? GPM_FRZ_TWO : GPM_FRZ_IDLE;   // [RQ22]
                default:      state_q <= GPM_FRZ_IDLE; // [RQ22]
            endcase
        end else if (rd_i && state_q == GPM_FRZ_TWO) begin
            state_q <= GPM_FRZ_IDLE;
        end
    end

    // Sticky freeze: only reset clears it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frozen_o   <= 16'h0000;
            key_done_o <= 1'b0;
        end else if (rd_i && !wr_i && state_q == GPM_FRZ_TWO) begin
            frozen_o   <= frozen_o | staged_q; // [RQ11]
            key_done_o <= 1'b1;
        end
    end
endmodule

// *** logic/gpm_port.sv ***
// One 16-pin GPIO port: registers, freeze, toggle and pad control
// How it works
// [RQ1] Analog mode turns off both pull resistors
// [RQ2] Analog mode turns off the output driver
// [RQ3] Analog mode disables the Schmitt input
// [RQ4] Analog pins read zero in sample register
// [RQ5] Alternate mode drives pad, push-pull or open-drain
// [RQ6] Alternate mode pad value comes from peripheral
// [RQ7] Alternate mode keeps Schmitt input, pulls selectable
// [RQ8] Sample register captures pads every clock
// [RQ9] Output value reads back last written value
// [RQ10] Freeze guards mode, drive, slew, pull, select
// [RQ11] Completed key sequence freezes chosen pins until reset
// [RQ12] Software should freeze power-module pins
// [RQ13] Flip-write ones invert outputs in one cycle
// [RQ14] Back-to-back flips give half-clock square wave
// [RQ15] Ports decode at base plus 0x400 spacing
// [RQ16] Mode register at 0x00, debug port reset differs
// [RQ17] Pin n mode field at bits 2n+1:2n
// [RQ18] Modes: input, output, alternate, analog
// [RQ19] Drive-type bit zero push-pull, one open-drain
// [RQ20] Sixteen alternate functions per pin selectable
// [RQ21] Writes to frozen pin fields are ignored
// [RQ22] Broken key sequence freezes nothing
`include "gpm_regs.svh"
module gpm_port #(
    parameter int PORT_INDEX = 1,
    parameter int PINS       = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire gpm_pkg::gpm_bus_req_t bus_i,
    input  wire logic [PINS-1:0]       pad_in_i,
    input  wire logic [PINS*16-1:0]    alt_out_i,
    input  wire logic [PINS*16-1:0]    alt_oe_i,
    output logic      [31:0]           rdata_o,
    output logic                       hit_o,
    output logic      [PINS-1:0]       pad_out_o,
    output logic      [PINS-1:0]       pad_oe_o,
    output logic      [PINS-1:0]       pad_pull_up_o,
    output logic      [PINS-1:0]       pad_pull_down_o,
    output logic      [PINS-1:0]       pad_schmitt_en_o,
    output logic      [PINS-1:0]       alt_in_o
);
    localparam logic [31:0] BASE = `GPM_PORT_BASE + `GPM_PORT_STRIDE * 32'(PORT_INDEX);
    localparam logic [31:0] MODE_RST = (PORT_INDEX == `GPM_DEBUG_PORT) ?
                                       `GPM_MODE_RST_DEBUG : `GPM_MODE_RST_OTHER;

    logic [31:0]     mode_q;
    logic [15:0]     drive_q;
    logic [31:0]     slew_q;
    logic [31:0]     pull_q;
    logic [31:0]     afsel0_q;
    logic [31:0]     afsel1_q;
    logic [15:0]     outval_q;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] sample_q;
    logic [15:0]     frozen;
    logic            key_done;
    logic [15:0]     staged;
    logic            sel;
    logic [11:0]     ofs;
    logic            wr_en;
    logic            rd_en;
    logic [31:0]     wmask2;
    logic [15:0]     wmask1;

    // Port select within its 1 KiB window
    assign sel   = bus_i.sel && (bus_i.addr[31:10] == BASE[31:10]); // [RQ15]
    assign ofs   = {2'h0, bus_i.addr[9:0]};
    assign wr_en = sel && bus_i.wr;
    assign rd_en = sel && !bus_i.wr;

    // Write masks that exclude frozen pins
    always_comb begin
        wmask1 = ~frozen;                              // [RQ21]
        wmask2 = 32'h00000000;
        for (int p = 0; p < 16; p++) begin
            wmask2[2*p +: 2] = {2{~frozen[p]}};        // [RQ21]
        end
    end

    // Protected configuration registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q   <= MODE_RST;                      // [RQ16]
            drive_q  <= 16'h0000;                      // [RQ19]
            slew_q   <= `GPM_CFG_RST;
            pull_q   <= `GPM_CFG_RST;
            afsel0_q <= `GPM_CFG_RST;
            afsel1_q <= `GPM_CFG_RST;
        end else if (wr_en) begin
            case (ofs)
                `GPM_OFS_MODE:  mode_q  <= (mode_q & ~wmask2) | (bus_i.wdata & wmask2); // [RQ10]
                `GPM_OFS_DRIVE: drive_q <= (drive_q & ~wmask1) | (bus_i.wdata[15:0] & wmask1);
                `GPM_OFS_SLEW:  slew_q  <= (slew_q & ~wmask2) | (bus_i.wdata & wmask2);
                `GPM_OFS_PULL:  pull_q  <= (pull_q & ~wmask2) | (bus_i.wdata & wmask2);
                `GPM_OFS_AFSEL0: begin
                    for (int p = 0; p < 8; p++) begin
                        if (!frozen[p]) afsel0_q[4*p +: 4] <= bus_i.wdata[4*p +: 4]; // [RQ20]
                    end
                end
                `GPM_OFS_AFSEL1: begin
                    for (int p = 0; p < 8; p++) begin
                        if (!frozen[p+8]) afsel1_q[4*p +: 4] <= bus_i.wdata[4*p +: 4];
                    end
                end
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Output value: plain write or single-cycle flip
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            outval_q <= 16'h0000;
        end else if (wr_en && ofs == `GPM_OFS_OUTVAL) begin
            outval_q <= bus_i.wdata[15:0];             // [RQ9]
        end else if (wr_en && ofs == `GPM_OFS_FLIP) begin
            outval_q <= outval_q ^ bus_i.wdata[15:0];  // [RQ13] [RQ14]
        end
    end

    // Freeze key sequence engine
    gpm_freeze u_freeze (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .wr_i       (wr_en && ofs == `GPM_OFS_FREEZE),
        .rd_i       (rd_en && ofs == `GPM_OFS_FREEZE),
        .wdata_i    (bus_i.wdata),
        .frozen_o   (frozen),
        .key_done_o (key_done),
        .staged_o   (staged)
    );

    // Two-stage pad synchroniser then per-clock sample
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pad_in_i;
            sync2_q <= sync1_q;
        end
    end

    // Per-pin pad control and sampling
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            gpm_pkg::gpm_pad_ctl_t ctl;
            logic [3:0]            fsel;
            logic                  analog;
            assign fsel   = (g < 8) ? afsel0_q[4*(g%8) +: 4] : afsel1_q[4*(g%8) +: 4];
            assign analog = (mode_q[2*g +: 2] == 2'h3); // [RQ17] [RQ18]
            gpm_pad_ctl u_ctl (
                .mode_i       (mode_q[2*g +: 2]),
                .open_drain_i (drive_q[g]),             // [RQ19]
                .pull_i       (pull_q[2*g +: 2]),
                .gpio_val_i   (outval_q[g]),
                .alt_val_i    (alt_out_i[16*g + fsel]), // [RQ20]
                .alt_oe_i     (alt_oe_i[16*g + fsel]),
                .ctl_o        (ctl)
            );
            // Registered pad controls and sample
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pad_out_o[g]        <= 1'b0;
                    pad_oe_o[g]         <= 1'b0;
                    pad_pull_up_o[g]    <= 1'b0;
                    pad_pull_down_o[g]  <= 1'b0;
                    pad_schmitt_en_o[g] <= 1'b0;
                    sample_q[g]         <= 1'b0;
                    alt_in_o[g]         <= 1'b0;
                end else begin
                    pad_out_o[g]        <= ctl.out_val;
                    pad_oe_o[g]         <= ctl.out_en;     // [RQ2] [RQ5]
                    pad_pull_up_o[g]    <= ctl.pull_up;    // [RQ1] [RQ7]
                    pad_pull_down_o[g]  <= ctl.pull_down;  // [RQ1]
                    pad_schmitt_en_o[g] <= ctl.schmitt_en; // [RQ3]
                    sample_q[g]         <= analog ? 1'b0 : sync2_q[g]; // [RQ4] [RQ8]
                    alt_in_o[g]         <= analog ? 1'b0 : sync2_q[g];
                end
            end
        end
    endgenerate

    // Registered read data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h00000000;
            hit_o   <= 1'b0;
        end else begin
            hit_o <= sel;
            case (ofs)
                `GPM_OFS_MODE:   rdata_o <= mode_q;
                `GPM_OFS_DRIVE:  rdata_o <= {16'h0000, drive_q};
                `GPM_OFS_SLEW:   rdata_o <= slew_q;
                `GPM_OFS_PULL:   rdata_o <= pull_q;
                `GPM_OFS_SAMPLE: rdata_o <= {16'h0000, sample_q};
                `GPM_OFS_OUTVAL: rdata_o <= {16'h0000, outval_q}; // [RQ9]
                `GPM_OFS_FREEZE: rdata_o <= {15'h0000, key_done, frozen};
                `GPM_OFS_AFSEL0: rdata_o <= afsel0_q;
                `GPM_OFS_AFSEL1: rdata_o <= afsel1_q;
                default:         rdata_o <= 32'h00000000;
            endcase
        end
    end

    // Analog pin 2: its sample bit reads zero from the next cycle
    a_analog_sample_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ4]
        (mode_q[5:4] == 2'h3) |=> !sample_q[2])
        else $error("analog pin sampled non-zero");

    // Analog pin never drives or pulls
    a_analog_no_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ2]
        (mode_q[5:4] == 2'h3) |=> !pad_oe_o[2] && !pad_pull_up_o[2] && !pad_pull_down_o[2])
        else $error("analog pin driven or pulled");

    // Analog pin has no Schmitt input
    a_analog_schmitt_off: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ3]
        (mode_q[5:4] == 2'h3) |=> !pad_schmitt_en_o[2])
        else $error("analog schmitt on");

    // Flip write inverts outputs next cycle
    a_flip_inverts: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ13]
        (wr_en && ofs == `GPM_OFS_FLIP)
        |=> outval_q == ($past(outval_q) ^ $past(bus_i.wdata[15:0])))
        else $error("flip did not invert");

    // Mode fields of frozen pins never change, whatever is written
    a_frozen_mode_held: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ21]
        (frozen != 16'h0000)
        |=> ((mode_q ^ $past(mode_q)) & ~$past(wmask2)) == 32'h00000000)
        else $error("frozen mode changed");

    // Freeze bits never drop without reset
    a_freeze_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ11]
        (frozen != 16'h0000) |=> (frozen & $past(frozen)) == $past(frozen))
        else $error("freeze cleared");

    // Output pin driving outval in push-pull
    a_output_drives: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ19]
        (mode_q[1:0] == 2'h1 && !drive_q[0]) |=> pad_oe_o[0] && pad_out_o[0] == $past(outval_q[0]))
        else $error("push-pull output wrong");

    // Sample follows synchronised pad for pin 3 in alternate mode
    a_sample_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RQ8]
        (mode_q[7:6] == 2'h2) |=> sample_q[3] == $past(sync2_q[3]))
        else $error("sample not current");
endmodule

// *** sim/gpm_pad_model.sv ***
// Behavioural pads and outside drivers facing the port's pad controls
module gpm_pad_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] out_i,
    input  wire logic [15:0] oe_i,
    input  wire logic [15:0] pull_up_i,
    input  wire logic [15:0] pull_down_i,
    input  wire logic [15:0] ext_en_i,
    input  wire logic [15:0] ext_val_i,
    output logic      [15:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] float_q = 16'hA5A5;

    // Undriven, unpulled pins wander so a stale level is never mistaken for a real one
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end

    // The port driver wins, then an outside driver, then the weak pulls
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            pad_o[n] = oe_i[n] ? out_i[n] :
                       ext_en_i[n] ? ext_val_i[n] :
                       pull_up_i[n] ? 1'b1 :
                       pull_down_i[n] ? 1'b0 : float_q[n];
        end
    end
endmodule

// *** sim/gpm_port_tb.sv ***
// Self-checking bench for the 16-pin port: pad modes, readback, freeze and toggle
`include "gpm_regs.svh"
module gpm_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] BASE = `GPM_PORT_BASE + `GPM_PORT_STRIDE;

    logic                  clk_i;
    logic                  reset_n_i;
    gpm_pkg::gpm_bus_req_t bus;
    logic [15:0]           pad_in, ext_en, ext_val, pad_out, pad_oe;
    logic [15:0]           pad_pu, pad_pd, pad_st, alt_in;
    logic [255:0]          alt_out, alt_oe;
    logic [31:0]           rdata, v;
    logic                  hit, exp_bit;
    int                    fails, comparisons;
    logic [11:0]           ofs_t[5] = '{`GPM_OFS_MODE, `GPM_OFS_PULL, `GPM_OFS_DRIVE,
                                         `GPM_OFS_AFSEL0, `GPM_OFS_SLEW};
    logic [31:0]           wr_t[5] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0]           ex_t[5] = '{32'h30, 32'h10, 32'hFFFB, 32'hFFFFF0FF, 32'hFFFFFFCF};

    gpm_port #(.PORT_INDEX(1), .PINS(16)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .pad_in_i(pad_in),
        .alt_out_i(alt_out), .alt_oe_i(alt_oe), .rdata_o(rdata), .hit_o(hit),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pull_up_o(pad_pu),
        .pad_pull_down_o(pad_pd), .pad_schmitt_en_o(pad_st), .alt_in_o(alt_in)
    );

    gpm_pad_model pads (
        .clk_i(clk_i), .out_i(pad_out), .oe_i(pad_oe), .pull_up_i(pad_pu),
        .pull_down_i(pad_pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in)
    );

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bus tasks let one edge pass idle, then hold the request over the edge that takes it
    task automatic wr(input logic [11:0] ofs, input logic [31:0] data);
        @(posedge clk_i);
        #1;
        bus = '{sel: 1'b1, wr: 1'b1, addr: BASE + {20'h0, ofs}, wdata: data};
        @(posedge clk_i);
        #1;
        bus.sel = 1'b0;
    endtask

    task automatic rd(input logic [31:0] addr, output logic [31:0] data);
        @(posedge clk_i);
        #1;
        bus = '{sel: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0};
        @(posedge clk_i);
        #1;
        data = rdata;
        bus.sel = 1'b0;
    endtask

    task automatic rchk(input string what, input logic [11:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        rd(BASE + {20'h0, ofs}, d);
        chk(what, d, exp);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic do_reset();
        reset_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
    endtask

    task automatic key_seq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        wr(`GPM_OFS_FREEZE, a);
        wr(`GPM_OFS_FREEZE, b);
        wr(`GPM_OFS_FREEZE, c);
        rd(BASE + `GPM_OFS_FREEZE, v);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_of_test();
    end

    initial begin
        bus = '0;
        alt_out = '0;
        alt_oe = '1;
        ext_en = 16'h0004;
        ext_val = 16'h0004;
        fails = 0;
        comparisons = 0;
        do_reset();
        // Reset values, unmapped offset and decode of the neighbouring port
        rchk("mode reset", `GPM_OFS_MODE, `GPM_MODE_RST_DEBUG);
        rchk("drive reset", `GPM_OFS_DRIVE, 32'h0);
        rchk("unmapped", 12'h018, 32'h0);
        chk("hit own port", {31'h0, hit}, 32'h1);
        rd(`GPM_PORT_BASE, v);
        chk("hit other port", {31'h0, hit}, 32'h0);
        // Pin 0 output, pin 2 analog with pull-up set, pin 3 alternate with pull-down
        wr(`GPM_OFS_MODE, 32'h000000B1);
        rchk("mode fields", `GPM_OFS_MODE, 32'h000000B1);
        wr(`GPM_OFS_PULL, 32'h00000090);
        wr(`GPM_OFS_OUTVAL, 32'h00000003);
        wr(`GPM_OFS_AFSEL0, 32'h00005000);
        alt_out[16*3+5] = 1'b1;
        step(4);
        chk("out pad", {30'h0, pad_oe[0], pad_out[0]}, 32'h3);
        chk("analog pulls", {30'h0, pad_pu[2], pad_pd[2]}, 32'h0);
        chk("analog oe", {31'h0, pad_oe[2]}, 32'h0);
        chk("analog schmitt", {31'h0, pad_st[2]}, 32'h0);
        rd(BASE + `GPM_OFS_SAMPLE, v);
        chk("analog sample", {31'h0, v[2]}, 32'h0);
        chk("alt drive", {30'h0, pad_oe[3], pad_out[3]}, 32'h3);
        chk("alt input", {30'h0, pad_st[3], pad_pd[3]}, 32'h3);
        chk("alt sample", {31'h0, v[3]}, 32'h1);
        chk("alt in", {30'h0, alt_in[3], alt_in[2]}, 32'h2);
        rchk("outval readback", `GPM_OFS_OUTVAL, 32'h3);
        // Open drain releases the pad on a one and pulls low on a zero
        wr(`GPM_OFS_DRIVE, 32'h00000008);
        step(1);
        chk("od release", {31'h0, pad_oe[3]}, 32'h0);
        alt_out[16*3+5] = 1'b0;
        step(1);
        chk("od low", {30'h0, pad_oe[3], pad_out[3]}, 32'h2);
        wr(`GPM_OFS_DRIVE, 32'h0);
        // Every alternate function index reaches the pad
        for (int f = 0; f < 16; f++) begin
            alt_out = 256'h1 << (16*3+f);
            wr(`GPM_OFS_AFSEL0, 32'(f) << 12);
            step(1);
            chk("alt select", {31'h0, pad_out[3]}, 32'h1);
        end
        // Flip pin 0 on three back-to-back cycles: square wave at half the clock
        bus = '{sel: 1'b1, wr: 1'b1, addr: BASE + `GPM_OFS_FLIP, wdata: 32'h1};
        exp_bit = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            #1;
            if (k == 2) begin
                bus.sel = 1'b0;
            end
            if (k > 0) begin
                exp_bit = ~exp_bit;
                chk("flip pad", {31'h0, pad_out[0]}, {31'h0, exp_bit});
            end
        end
        rchk("flip others", `GPM_OFS_OUTVAL, 32'h2);
        // A broken key sequence freezes nothing
        key_seq(32'h00010004, 32'h00000004, 32'h00000004);
        chk("key aborted", v, 32'h0);
        // Freeze pin 2, the pin treated as a power-module driver
        key_seq(32'h00010004, 32'h00000004, 32'h00010004);
        // The closing read latches its data before the freeze lands, so read again
        rchk("key done", `GPM_OFS_FREEZE, 32'h00010004);
        for (int i = 0; i < 5; i++) begin
            wr(ofs_t[i], wr_t[i]);
            rchk("frozen field", ofs_t[i], ex_t[i]);
        end
        // The freeze lasts only until the next reset
        do_reset();
        rchk("mode reset again", `GPM_OFS_MODE, `GPM_MODE_RST_DEBUG);
        wr(`GPM_OFS_MODE, 32'h0);
        rchk("unfrozen", `GPM_OFS_MODE, 32'h0);
        end_of_test();
    end
endmodule
